// ==== rtl/cifr_top.sv ====
// How it works
// R1: A radio interrupt sets both radio flag bits together.
// R2: Software setting either radio bit alone raises the radio request.
// R3: All flags reset to 0; 1 means pending, 0 means not pending.
// R4: Software keeps reserved bit 6 of the fourth register at 0.
// R5: A set reserved bit 6 keeps its request asserted indefinitely.
// R6: Timer flags bits 1-4 set on timer events, cleared on vectoring.
// R7: Bit 7 is the sleep timer flag, readable and writable.
// R8: Bit 5 is the port 0 flag, readable and writable.
// R9: Bit 0 is the DMA complete flag, readable and writable.
// R10: Software clears non-hardware-cleared flags by writing 0 in its handler.
`timescale 1ns/1ns
module cifr_top
   import cifr_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic [ADDR_W-1:0]      reg_addr,
   input  wire logic [CIFR_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [CIFR_DATA_W-1:0] reg_rdata_q,
   input  wire logic                   radio_evt,
   input  wire logic                   sleep_evt,
   input  wire logic                   port_zero_evt,
   input  wire logic [3:0]             timer_evt,
   input  wire logic                   dma_done_evt,
   input  wire logic [3:0]             timer_vec_ack,
   output logic                        radio_req_q,
   output logic      [7:0]             pend_four_q,
   output logic                        irq_q
);

   // The decoder compares the whole address with the eight-bit offsets, so it needs at least eight bits.
   if (ADDR_W < 8)
   begin : g_bad_addr_w
      $error("cifr_top: ADDR_W must be at least 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode.

   logic [CIFR_DATA_W-1:0] flag_three_q;
   logic [CIFR_DATA_W-1:0] flag_three_d;
   logic [CIFR_DATA_W-1:0] flag_four_q;
   logic [CIFR_DATA_W-1:0] flag_four_d;
   logic [CIFR_DATA_W-1:0] evt_status_q;
   logic [CIFR_DATA_W-1:0] evt_status_d;
   logic [CIFR_DATA_W-1:0] evt_mask_q;
   logic [CIFR_DATA_W-1:0] evt_mask_d;
   logic [CIFR_DATA_W-1:0] reg_rdata_d;
   logic                   radio_req_d;
   logic [7:0]             pend_four_d;
   logic                   irq_d;
   logic                   hit_three;
   logic                   hit_four;
   logic                   hit_status;
   logic                   hit_mask;
   logic [7:0]             timer_set;
   logic [7:0]             timer_clr;
   logic [7:0]             four_set;
   logic [7:0]             evt_hits;

   // Upper address bits must be zero for any register to answer.
   assign hit_three  = (reg_addr == ADDR_W'(CIFR_OFS_FLAG_THREE));
   assign hit_four   = (reg_addr == ADDR_W'(CIFR_OFS_FLAG_FOUR));
   assign hit_status = (reg_addr == ADDR_W'(CIFR_OFS_EVT_STATUS));
   assign hit_mask   = (reg_addr == ADDR_W'(CIFR_OFS_EVT_MASK));

   ////////////////////////////////////////////////////////////////////////////
   // Per-timer set and vector-clear lanes in the fourth flag register.

   for (genvar i = 0; i < 8; i++)
   begin : g_timer_lane
      if (i >= CIFR_TIMER_ONE_BIT && i <= CIFR_TIMER_FOUR_BIT)
      begin : g_tmr
         assign timer_set[i] = timer_evt[i-CIFR_TIMER_ONE_BIT];
         assign timer_clr[i] = timer_vec_ack[i-CIFR_TIMER_ONE_BIT];
      end
      else
      begin : g_none
         assign timer_set[i] = 1'b0;
         assign timer_clr[i] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag registers next state.

   // Writes store, vectoring clears, and a hardware set beats both.
   always_comb
   begin
      flag_three_d = flag_three_q;
      if (reg_wr && hit_three)
      begin
         flag_three_d = reg_wdata & CIFR_FLAG_THREE_USED; // R10
      end
      if (radio_evt)
      begin
         flag_three_d[CIFR_RADIO_HI_BIT] = 1'b1; // R1
         flag_three_d[CIFR_RADIO_LO_BIT] = 1'b1; // R1
      end

      four_set = timer_set; // R6
      four_set[CIFR_SLEEP_BIT]     = sleep_evt; // R7
      four_set[CIFR_PORT_ZERO_BIT] = port_zero_evt; // R8
      four_set[CIFR_DMA_DONE_BIT]  = dma_done_evt; // R9

      flag_four_d = flag_four_q;
      if (reg_wr && hit_four)
      begin
         // Bit 6 is stored as written so a stray set stays visible.
         flag_four_d = reg_wdata; // R7 R8 R9
      end
      flag_four_d = (flag_four_d & ~timer_clr) | four_set; // R6
   end

   // Flag registers, cleared by reset.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flag_three_q <= CIFR_RST_FLAG_THREE; // R3
         flag_four_q  <= CIFR_RST_FLAG_FOUR; // R3
      end
      else
      begin
         flag_three_q <= flag_three_d;
         flag_four_q  <= flag_four_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request outputs to the CPU.

   // Either radio bit alone requests service; no hardware clear on bit 6.
   always_comb
   begin
      radio_req_d = |flag_three_d[CIFR_RADIO_HI_BIT:CIFR_RADIO_LO_BIT]; // R2
      pend_four_d = flag_four_d; // R5
   end

   // Request flops track the flags in the same cycle.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         radio_req_q <= 1'b0;
         pend_four_q <= 8'h00;
      end
      else
      begin
         radio_req_q <= radio_req_d;
         pend_four_q <= pend_four_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status, mask and interrupt line.

   // Sticky event bits, cleared by writing one; a new event wins.
   always_comb
   begin
      evt_hits = 8'h00;
      evt_hits[CIFR_EVT_RADIO]     = radio_evt;
      evt_hits[CIFR_EVT_SLEEP]     = sleep_evt;
      evt_hits[CIFR_EVT_PORT_ZERO] = port_zero_evt;
      evt_hits[CIFR_EVT_TIMER_LO +: CIFR_TIMER_COUNT] = timer_evt;
      evt_hits[CIFR_EVT_DMA]       = dma_done_evt;
      evt_status_d = evt_status_q;
      if (reg_wr && hit_status)
      begin
         evt_status_d = evt_status_q & ~reg_wdata;
      end
      evt_status_d = evt_status_d | evt_hits;
      evt_mask_d = evt_mask_q;
      if (reg_wr && hit_mask)
      begin
         evt_mask_d = reg_wdata;
      end
      irq_d = |(evt_status_d & evt_mask_d);
   end

   // Status, mask and interrupt flops.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         evt_status_q <= CIFR_RST_EVT_STATUS;
         evt_mask_q   <= CIFR_RST_EVT_MASK;
         irq_q        <= 1'b0;
      end
      else
      begin
         evt_status_q <= evt_status_d;
         evt_mask_q   <= evt_mask_d;
         irq_q        <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port.

   // Read data appear the cycle after the strobe; other times read zero.
   always_comb
   begin
      reg_rdata_d = '0;
      if (reg_rd)
      begin
         if (hit_three)
         begin
            reg_rdata_d = flag_three_q;
         end
         else if (hit_four)
         begin
            reg_rdata_d = flag_four_q;
         end
         else if (hit_status)
         begin
            reg_rdata_d = evt_status_q;
         end
         else if (hit_mask)
         begin
            reg_rdata_d = evt_mask_q;
         end
      end
   end

   // Read data register.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         reg_rdata_q <= '0;
      end
      else
      begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   logic       wr_four;
   logic [3:0] ack_only;

   // Helper terms that the checks read.
   assign wr_four  = reg_wr && hit_four;
   assign ack_only = timer_vec_ack & ~timer_evt;

   sequence s_radio_evt;
      radio_evt;
   endsequence

   sequence s_both_radio_set;
      flag_three_q[1:0] == 2'b11 ##0 radio_req_q;
   endsequence

   property p_radio_both;
      @(posedge clk) disable iff (sys_rst)
      s_radio_evt |=> s_both_radio_set;
   endproperty
   a_radio_both : assert property (p_radio_both) // R1
      else $error("Radio event did not set both radio flag bits.");

   property p_radio_single;
      @(posedge clk) disable iff (sys_rst)
      (flag_three_q[1] != flag_three_q[0]) |-> radio_req_q;
   endproperty
   a_radio_single : assert property (p_radio_single) // R2
      else $error("Single radio flag bit gave no request.");

   property p_reset_clear;
      @(posedge clk)
      sys_rst |=> (flag_three_q == 8'h00 && flag_four_q == 8'h00 && !irq_q);
   endproperty
   a_reset_clear : assert property (p_reset_clear) // R3
      else $error("Flags not clear after reset.");

   property p_reserved_hold;
      @(posedge clk) disable iff (sys_rst)
      (flag_four_q[6] && !wr_four) |=> (flag_four_q[6] && pend_four_q[6]);
   endproperty
   a_reserved_hold : assert property (p_reserved_hold) // R5
      else $error("Reserved request dropped without a write.");

   property p_timer_set;
      @(posedge clk) disable iff (sys_rst)
      (timer_evt != 4'h0) |=>
         ((flag_four_q[4:1] & $past(timer_evt)) == $past(timer_evt));
   endproperty
   a_timer_set : assert property (p_timer_set) // R6
      else $error("Timer event did not set its flag.");

   property p_timer_clear;
      @(posedge clk) disable iff (sys_rst)
      ((ack_only != 4'h0) && !wr_four) |=>
         ((flag_four_q[4:1] & $past(ack_only)) == 4'h0);
   endproperty
   a_timer_clear : assert property (p_timer_clear) // R6
      else $error("Vectoring did not clear the timer flag.");

   property p_sleep_rw;
      @(posedge clk) disable iff (sys_rst)
      (wr_four && !sleep_evt) |=> (flag_four_q[7] == $past(reg_wdata[7]));
   endproperty
   a_sleep_rw : assert property (p_sleep_rw) // R7
      else $error("Sleep timer flag did not take the written value.");

   property p_port_zero_rw;
      @(posedge clk) disable iff (sys_rst)
      (wr_four && !port_zero_evt) |=>
         (flag_four_q[5] == $past(reg_wdata[5]));
   endproperty
   a_port_zero_rw : assert property (p_port_zero_rw) // R8
      else $error("Port 0 flag did not take the written value.");

   property p_dma_rw;
      @(posedge clk) disable iff (sys_rst)
      (wr_four && !dma_done_evt) |=> (flag_four_q[0] == $past(reg_wdata[0]));
   endproperty
   a_dma_rw : assert property (p_dma_rw) // R9
      else $error("DMA flag did not take the written value.");

   sequence s_read_four;
      reg_rd && hit_four;
   endsequence

   property p_read_four;
      @(posedge clk) disable iff (sys_rst)
      s_read_four |=> (reg_rdata_q == $past(flag_four_q));
   endproperty
   a_read_four : assert property (p_read_four)
      else $error("Read of fourth flag register returned wrong data.");

   property p_irq_level;
      @(posedge clk) disable iff (sys_rst)
      irq_q == |(evt_status_q & evt_mask_q);
   endproperty
   a_irq_level : assert property (p_irq_level)
      else $error("Interrupt line disagrees with status and mask.");

endmodule

// ==== rtl/cifr_pkg.sv ====
// Shared constants for the CPU interrupt flag register block.
package cifr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the special function register port.
   localparam logic [7:0] CIFR_OFS_FLAG_THREE = 8'h9b;
   localparam logic [7:0] CIFR_OFS_FLAG_FOUR  = 8'hc0;
   localparam logic [7:0] CIFR_OFS_EVT_STATUS = 8'hf8;
   localparam logic [7:0] CIFR_OFS_EVT_MASK   = 8'hf9;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [7:0] CIFR_RST_FLAG_THREE = 8'h00;
   localparam logic [7:0] CIFR_RST_FLAG_FOUR  = 8'h00;
   localparam logic [7:0] CIFR_RST_EVT_STATUS = 8'h00;
   localparam logic [7:0] CIFR_RST_EVT_MASK   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the third flag register.
   localparam int CIFR_RADIO_LO_BIT = 0;
   localparam int CIFR_RADIO_HI_BIT = 1;
   localparam logic [7:0] CIFR_FLAG_THREE_USED = 8'h03;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the fourth flag register.
   localparam int CIFR_DMA_DONE_BIT   = 0;
   localparam int CIFR_TIMER_ONE_BIT  = 1;
   localparam int CIFR_TIMER_FOUR_BIT = 4;
   localparam int CIFR_PORT_ZERO_BIT  = 5;
   localparam int CIFR_RESERVED_BIT   = 6;
   localparam int CIFR_SLEEP_BIT      = 7;
   localparam int CIFR_TIMER_COUNT    = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the event status and mask registers.
   localparam int CIFR_EVT_RADIO     = 0;
   localparam int CIFR_EVT_SLEEP     = 1;
   localparam int CIFR_EVT_PORT_ZERO = 2;
   localparam int CIFR_EVT_TIMER_LO  = 3;
   localparam int CIFR_EVT_DMA       = 7;

   // Width of the register data port.
   localparam int CIFR_DATA_W = 8;

endpackage

// ==== tb/cifr_src.sv ====
`timescale 1ns/1ns
// Peripheral sources and CPU vectoring seen from the flag block.
module cifr_src
   import cifr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] cmd,
   input  wire logic [7:0]  pend_four_q,
   output logic             radio_evt,
   output logic             sleep_evt,
   output logic             port_zero_evt,
   output logic      [3:0]  timer_evt,
   output logic             dma_done_evt,
   output logic      [3:0]  timer_vec_ack
);

   ////////////////////////////////////////////////////////////////////////////
   // Events follow the command one cycle later; the CPU only vectors to a
   // timer routine whose request it sees pending.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         {radio_evt, sleep_evt, port_zero_evt} <= 3'h0;
         timer_evt     <= 4'h0;
         dma_done_evt  <= 1'b0;
         timer_vec_ack <= 4'h0;
      end
      else
      begin
         {radio_evt, sleep_evt, port_zero_evt} <= cmd[2:0];
         timer_evt     <= cmd[6:3];
         dma_done_evt  <= cmd[7];
         timer_vec_ack <= cmd[11:8] & pend_four_q[4:1];
      end
   end

endmodule

// ==== tb/test_cifr_top.sv ====
`timescale 1ns/1ns
// Self-checking bench for the interrupt flag block.
module test_cifr_top
   import cifr_pkg::*;
;
   logic        clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata_q;
   logic        radio_evt;
   logic        sleep_evt;
   logic        port_zero_evt;
   logic [3:0]  timer_evt;
   logic        dma_done_evt;
   logic [3:0]  timer_vec_ack;
   logic        radio_req_q;
   logic [7:0]  pend_four_q;
   logic        irq_q;
   logic [11:0] cmd;
   logic [1:0]  m3;
   logic [7:0]  m4, ms, mm, mrd;
   logic [31:0] r;
   logic [7:0]  a;
   logic [7:0]  ofs [4];
   int          mismatches;
   int          n_compared;
   bit          chk_on;

   cifr_top cifr_top_inst (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .radio_evt(radio_evt),
      .sleep_evt(sleep_evt), .port_zero_evt(port_zero_evt),
      .timer_evt(timer_evt), .dma_done_evt(dma_done_evt),
      .timer_vec_ack(timer_vec_ack), .radio_req_q(radio_req_q),
      .pend_four_q(pend_four_q), .irq_q(irq_q));

   cifr_src cifr_src_inst (.clk(clk), .sys_rst(sys_rst), .cmd(cmd),
      .pend_four_q(pend_four_q), .radio_evt(radio_evt),
      .sleep_evt(sleep_evt), .port_zero_evt(port_zero_evt),
      .timer_evt(timer_evt), .dma_done_evt(dma_done_evt),
      .timer_vec_ack(timer_vec_ack));

   ////////////////////////////////////////////////////////////////////////////
   // Clock of 8 ns period.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Pseudo-random step.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // Compares one value and counts it.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic summarize();
      if (mismatches == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One bus cycle plus one source command, launched after a rising edge.
   task automatic bus(input logic w, input logic rd, input logic [7:0] ad,
                      input logic [7:0] d, input logic [11:0] c);
      @(posedge clk);
      reg_wr    <= w;
      reg_rd    <= rd;
      reg_addr  <= ad;
      reg_wdata <= d;
      cmd       <= c;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reference model: write first, then vector clear, then events win.
   always @(posedge clk)
   begin
      if (sys_rst)
         {m3, m4, ms, mm, mrd} = '0;
      else
      begin
         mrd = 8'h00;
         if (reg_rd)
            case (reg_addr)
               CIFR_OFS_FLAG_THREE: mrd = {6'h00, m3};
               CIFR_OFS_FLAG_FOUR:  mrd = m4;
               CIFR_OFS_EVT_STATUS: mrd = ms;
               CIFR_OFS_EVT_MASK:   mrd = mm;
               default:             mrd = 8'h00;
            endcase
         if (reg_wr)
            case (reg_addr)
               CIFR_OFS_FLAG_THREE: m3 = reg_wdata[1:0];
               CIFR_OFS_FLAG_FOUR:  m4 = reg_wdata;
               CIFR_OFS_EVT_STATUS: ms = ms & ~reg_wdata;
               CIFR_OFS_EVT_MASK:   mm = reg_wdata;
               default:             ;
            endcase
         m4[4:1] = m4[4:1] & ~timer_vec_ack;
         if (radio_evt)
            m3 = 2'b11;
         ms |= {dma_done_evt, timer_evt, port_zero_evt, sleep_evt, radio_evt};
         m4 |= {sleep_evt, 1'b0, port_zero_evt, timer_evt, dma_done_evt};
      end
   end

   // Every output is compared with the model once settled.
   always @(negedge clk)
   begin
      if (chk_on)
      begin
         chk(reg_rdata_q, mrd);
         chk(pend_four_q, m4);
         chk({7'h00, radio_req_q}, {7'h00, |m3});
         chk({7'h00, irq_q}, {7'h00, |(ms & mm)});
      end
   end

   // Cuts a hang short.
   initial
   begin
      repeat (6000) @(posedge clk);
      mismatches++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      ofs = '{CIFR_OFS_FLAG_THREE, CIFR_OFS_FLAG_FOUR, CIFR_OFS_EVT_STATUS,
              CIFR_OFS_EVT_MASK};
      {reg_addr, reg_wdata, reg_wr, reg_rd, cmd} = '0;
      {mismatches, n_compared, chk_on} = '0;
      r = 32'hc0dc0bf7;
      sys_rst = 1'b1;
      @(posedge clk);
      chk_on = 1'b1;
      repeat (11) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         bus(1'b0, 1'b1, ofs[i], 8'h00, 12'h000);
      bus(1'b1, 1'b0, CIFR_OFS_FLAG_THREE, 8'h01, 12'h000);
      bus(1'b1, 1'b0, CIFR_OFS_FLAG_THREE, 8'h02, 12'h000);
      bus(1'b1, 1'b0, CIFR_OFS_FLAG_THREE, 8'h00, 12'h000);
      bus(1'b0, 1'b0, 8'h00, 8'h00, 12'h001);
      bus(1'b0, 1'b1, CIFR_OFS_FLAG_THREE, 8'h00, 12'h000);
      for (int i = 0; i < 2000; i++)
      begin
         r = xs(r);
         a = (r[4:2] == 3'h0) ? r[31:24] : ofs[r[1:0]];
         bus(r[7:6] == 2'h1, r[7:6] == 2'h2, a,
             (a == CIFR_OFS_FLAG_FOUR) ? r[15:8] & 8'hbf : r[15:8],
             r[27:16] & 12'(xs(r) >> 4));
      end
      // Reset again in mid-run with flags set, then read every register.
      bus(1'b0, 1'b0, 8'h00, 8'h00, 12'h000);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         bus(1'b0, 1'b1, ofs[i], 8'h00, 12'h000);
      bus(1'b1, 1'b0, CIFR_OFS_FLAG_FOUR, 8'h40, 12'h000);
      repeat (8) bus(1'b0, 1'b0, 8'h00, 8'h00, 12'hfff);
      bus(1'b0, 1'b0, 8'h00, 8'h00, 12'h000);
      @(negedge clk);
      chk({7'h00, pend_four_q[6]}, 8'h01);
      summarize();
   end

endmodule
